// >>> rtl/vpic_ctrl.sv
// vectored priority interrupt controller top
// Contract
// - fast request asserted only by the external fast-request pin
// - standard request from any peripheral or the three external standard pins; during service only from a level above the serviced one
// - eight-level priority encoder, level per source set by software
// - each standard source maskable, the fast source not; status register names the serviced source
// - internal sources selectable edge or level sensitive
// - external sources rising, falling, high or low sensitive
`timescale 1ns/1ps
module vpic_ctrl
(
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic [7:0] periph_irq,
  input wire logic ext_fast_req_pin,
  input wire logic ext_std_req_pin_0,
  input wire logic ext_std_req_pin_1,
  input wire logic ext_std_req_pin_2,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic cpu_fast_req_n,
  output logic cpu_std_req_n
);

  localparam int NS = vpic_pkg::NUM_SRC;
  localparam logic [7:0] SMR_END = 8'(vpic_pkg::OFS_SMR_BASE + 4 * NS);

  // ---------------------------------------------------------------
  // configuration registers
  // ---------------------------------------------------------------
  logic [5:0] smr_r [NS];
  logic [1:0] fast_type_r;
  logic [NS-1:0] enable_r;
  logic [NS-1:0] src_in;
  logic [NS-1:0] pend;
  logic [NS-1:0] clr;
  logic [NS-1:0] active;
  logic fast_pend;
  logic fast_clr;
  logic wr_smr;
  logic [3:0] wr_idx;
  logic rd_vec;

  assign src_in = {ext_std_req_pin_2, ext_std_req_pin_1, ext_std_req_pin_0, periph_irq};
  assign wr_smr = reg_wr && (reg_addr < SMR_END) && (reg_addr[1:0] == 2'h0);
  assign wr_idx = reg_addr[5:2];
  assign rd_vec = reg_rd && (reg_addr == vpic_pkg::OFS_VECTOR);

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      for (int i = 0; i < NS; i++)
        smr_r[i] <= vpic_pkg::SMR_RESET;
    end
    else if (wr_smr)
    begin
      smr_r[wr_idx] <= reg_wdata[5:0];
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      fast_type_r <= vpic_pkg::TYPE_LVL_LOW;
    else if (reg_wr && reg_addr == vpic_pkg::OFS_FAST_MODE)
      fast_type_r <= reg_wdata[1:0];
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      enable_r <= '0;
    else if (reg_wr && reg_addr == vpic_pkg::OFS_ENABLE)
      enable_r <= enable_r | reg_wdata[NS-1:0];
    else if (reg_wr && reg_addr == vpic_pkg::OFS_DISABLE)
      enable_r <= enable_r & ~reg_wdata[NS-1:0];
  end

  // ---------------------------------------------------------------
  // source conditioning
  // ---------------------------------------------------------------
  // sensitivity per source
  genvar g;
  generate
    for (g = 0; g < NS; g++)
    begin : g_src
      vpic_src_cond u_cond
      (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .src_in(src_in[g]),
        .src_type(smr_r[g][vpic_pkg::FLD_TYPE_LSB +: vpic_pkg::FLD_TYPE_W]),
        .clr(clr[g]),
        .pend(pend[g])
      );
    end
  endgenerate

  vpic_src_cond u_fast
  (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .src_in(ext_fast_req_pin),
    .src_type(fast_type_r),
    .clr(fast_clr),
    .pend(fast_pend)
  );

  // ---------------------------------------------------------------
  // priority encoder and service state
  // ---------------------------------------------------------------
  vpic_pkg::vpic_state_t state_r;
  logic [3:0] best_idx;
  logic [2:0] best_pri;
  logic best_vld;
  logic [3:0] vec_r;
  logic [2:0] cur_pri_r;
  logic eoi;

  assign active = pend & enable_r;
  assign eoi = reg_wr && reg_addr == vpic_pkg::OFS_EOI;
  assign fast_clr = reg_wr && reg_addr == vpic_pkg::OFS_CLEAR && reg_wdata[NS];

  // highest level wins, lowest index on a tie
  always_comb
  begin
    best_idx = vpic_pkg::VEC_NONE;
    best_pri = 3'h0;
    best_vld = 1'b0;
    for (int i = 0; i < NS; i++)
    begin
      if (active[i] && (!best_vld || smr_r[i][2:0] > best_pri))
      begin
        best_idx = 4'(i);
        best_pri = smr_r[i][2:0];
        best_vld = 1'b1;
      end
    end
  end

  // edge flags clear on vector read or explicit clear
  always_comb
  begin
    clr = '0;
    if (reg_wr && reg_addr == vpic_pkg::OFS_CLEAR)
      clr = reg_wdata[NS-1:0];
    if (rd_vec && best_vld)
      clr[best_idx] = 1'b1;
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_r <= vpic_pkg::VPIC_IDLE;
      vec_r <= vpic_pkg::VEC_NONE;
      cur_pri_r <= 3'h0;
    end
    else
    begin
      unique case (state_r)
        vpic_pkg::VPIC_IDLE:
          if (best_vld)
            state_r <= vpic_pkg::VPIC_REQ;
        vpic_pkg::VPIC_REQ:
          if (rd_vec && best_vld)
          begin
            vec_r <= best_idx;
            cur_pri_r <= best_pri;
            state_r <= vpic_pkg::VPIC_SERV;
          end
          else if (!best_vld)
            state_r <= vpic_pkg::VPIC_IDLE;
        vpic_pkg::VPIC_SERV:
          if (eoi)
          begin
            vec_r <= vpic_pkg::VEC_NONE;
            state_r <= vpic_pkg::VPIC_IDLE;
          end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // processor request outputs
  // ---------------------------------------------------------------
  // fast request only from the fast pin
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      cpu_fast_req_n <= 1'b1;
    else
      cpu_fast_req_n <= ~fast_pend;
  end

  // standard request from any enabled source, or in service only from one of a higher level
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      cpu_std_req_n <= 1'b1;
    else if (state_r == vpic_pkg::VPIC_SERV)
      cpu_std_req_n <= ~(best_vld && best_pri > cur_pri_r);
    else
      cpu_std_req_n <= ~best_vld;
  end

  // ---------------------------------------------------------------
  // register read
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      reg_rdata <= 32'h0000_0000;
    else if (reg_rd)
    begin
      reg_rdata <= 32'h0000_0000;
      if (reg_addr < SMR_END && reg_addr[1:0] == 2'h0)
        reg_rdata[5:0] <= smr_r[wr_idx];
      else
        unique case (reg_addr)
          vpic_pkg::OFS_MASK: reg_rdata[NS-1:0] <= enable_r;
          vpic_pkg::OFS_PENDING: reg_rdata[NS:0] <= {fast_pend, pend};
          vpic_pkg::OFS_VECTOR: reg_rdata[3:0] <= best_vld ? best_idx : vpic_pkg::VEC_NONE;
          vpic_pkg::OFS_FAST_MODE: reg_rdata[1:0] <= fast_type_r;
          vpic_pkg::OFS_STATUS: reg_rdata[5:0] <= {state_r, vec_r};
          default: reg_rdata <= 32'h0000_0000;
        endcase
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  a_fast_only_pin: assert property (@(posedge clk_sys) disable iff (!arst_n)
    !cpu_fast_req_n |-> $past(fast_pend))
    else $error("fast request without fast pin");

  a_std_from_src: assert property (@(posedge clk_sys) disable iff (!arst_n)
    !cpu_std_req_n |-> $past(|active))
    else $error("standard request with no active source");

  a_std_release: assert property (@(posedge clk_sys) disable iff (!arst_n)
    !(|active) |=> cpu_std_req_n)
    else $error("standard request not released");

  a_std_assert: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (|active && state_r != vpic_pkg::VPIC_SERV) |=> !cpu_std_req_n)
    else $error("standard request missing");

  a_mask_blocks: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (enable_r == '0) |=> cpu_std_req_n)
    else $error("masked sources raised request");

  a_vec_latch: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (state_r == vpic_pkg::VPIC_REQ && rd_vec && best_vld) |=> vec_r == $past(best_idx))
    else $error("vector not latched");

  a_pri_best: assert property (@(posedge clk_sys) disable iff (!arst_n)
    best_vld |-> active[best_idx])
    else $error("encoder picked inactive source");

  a_edge_hold: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (smr_r[0][5:4] == vpic_pkg::TYPE_EDGE_RISE && $rose(src_in[0]) && !clr[0])
      |=> pend[0])
    else $error("rising edge not captured");

  a_ext_level: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (smr_r[8][5:4] == vpic_pkg::TYPE_LVL_LOW) |-> pend[8] == !src_in[8])
    else $error("low level source mismatch");

  a_fast_release: assert property (@(posedge clk_sys) disable iff (!arst_n)
    !fast_pend |=> cpu_fast_req_n)
    else $error("fast request not released");

  a_fast_fall: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (fast_type_r == vpic_pkg::TYPE_EDGE_FALL && $fell(ext_fast_req_pin)) |=> fast_pend)
    else $error("fast falling edge not captured");

  a_serv_quiet: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (state_r == vpic_pkg::VPIC_SERV && !(best_vld && best_pri > cur_pri_r)) |=> cpu_std_req_n)
    else $error("request during service without higher level");

  a_vec_none: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (rd_vec && !best_vld) |=> reg_rdata[3:0] == vpic_pkg::VEC_NONE)
    else $error("vector read without source not empty");

  a_int_level: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (smr_r[1][5:4] == vpic_pkg::TYPE_LVL_HIGH) |-> pend[1] == src_in[1])
    else $error("high level source mismatch");

endmodule // vpic_ctrl

// >>> rtl/vpic_pkg.sv
// shared constants for the vectored priority interrupt controller
package vpic_pkg;

  // ---------------------------------------------------------------
  // source layout
  // ---------------------------------------------------------------
  localparam int NUM_INT = 8;
  localparam int NUM_EXT = 3;
  localparam int NUM_SRC = 11;
  localparam int SRC_W = 4;
  localparam int PRI_W = 3;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // ---------------------------------------------------------------
  // register offsets (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_SMR_BASE = 8'h00;
  localparam logic [7:0] OFS_ENABLE = 8'h40;
  localparam logic [7:0] OFS_DISABLE = 8'h44;
  localparam logic [7:0] OFS_MASK = 8'h48;
  localparam logic [7:0] OFS_PENDING = 8'h4C;
  localparam logic [7:0] OFS_CLEAR = 8'h50;
  localparam logic [7:0] OFS_VECTOR = 8'h54;
  localparam logic [7:0] OFS_EOI = 8'h58;
  localparam logic [7:0] OFS_FAST_MODE = 8'h5C;
  localparam logic [7:0] OFS_STATUS = 8'h60;

  // ---------------------------------------------------------------
  // source mode fields
  // ---------------------------------------------------------------
  localparam int FLD_PRI_LSB = 0;
  localparam int FLD_TYPE_LSB = 4;
  localparam int FLD_TYPE_W = 2;
  localparam logic [1:0] TYPE_LVL_LOW = 2'h0;
  localparam logic [1:0] TYPE_EDGE_FALL = 2'h1;
  localparam logic [1:0] TYPE_LVL_HIGH = 2'h2;
  localparam logic [1:0] TYPE_EDGE_RISE = 2'h3;
  localparam logic [5:0] SMR_RESET = 6'h20;
  localparam logic [SRC_W-1:0] VEC_NONE = 4'hF;
  localparam logic [DATA_W-1:0] STATUS_MASK = 32'h0000_00FF;

  typedef enum logic [1:0] {
    VPIC_IDLE = 2'b00,
    VPIC_REQ = 2'b01,
    VPIC_SERV = 2'b11
  } vpic_state_t;

endpackage

// >>> rtl/vpic_src_cond.sv
// per-source sensitivity conditioning: edge or level, either polarity
`timescale 1ns/1ps
module vpic_src_cond
(
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic src_in,
  input wire logic [1:0] src_type,
  input wire logic clr,
  output logic pend
);

  logic prev_r;
  logic edge_pend_r;
  logic is_edge;
  logic hit;

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      prev_r <= 1'b0;
    else
      prev_r <= src_in;
  end

  always_comb
  begin
    is_edge = src_type[0];
    unique case (src_type)
      vpic_pkg::TYPE_EDGE_RISE: hit = src_in & ~prev_r;
      vpic_pkg::TYPE_EDGE_FALL: hit = ~src_in & prev_r;
      vpic_pkg::TYPE_LVL_HIGH: hit = src_in;
      vpic_pkg::TYPE_LVL_LOW: hit = ~src_in;
    endcase
  end

  // set wins over clear
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      edge_pend_r <= 1'b0;
    else if (is_edge && hit)
      edge_pend_r <= 1'b1;
    else if (clr || !is_edge)
      edge_pend_r <= 1'b0;
  end

  assign pend = is_edge ? edge_pend_r : hit;

endmodule // vpic_src_cond

// >>> sim/vpic_cpu_model.sv
// processor core model: counts request assertions on both request inputs
`timescale 1ns/1ps
module vpic_cpu_model
(
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic cpu_fast_req_n,
  input wire logic cpu_std_req_n,
  output logic [7:0] fast_cnt,
  output logic [7:0] std_cnt
);
  logic fast_q;
  logic std_q;
  // counts each falling request, as an entry
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      fast_q <= 1'b1;
      std_q <= 1'b1;
      fast_cnt <= 8'h00;
      std_cnt <= 8'h00;
    end
    else
    begin
      fast_q <= cpu_fast_req_n;
      std_q <= cpu_std_req_n;
      if (fast_q && !cpu_fast_req_n)
        fast_cnt <= fast_cnt + 8'h01;
      if (std_q && !cpu_std_req_n)
        std_cnt <= std_cnt + 8'h01;
    end
  end
endmodule // vpic_cpu_model

// >>> sim/tb.sv
// self-checking testbench for the interrupt controller
`timescale 1ns/1ps
module tb;
  logic clk_sys = 1'b0;
  logic arst_n = 1'b0;
  logic [10:0] src_v = 11'h000;
  logic ext_fast_req_pin = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata, rv;
  logic cpu_fast_req_n, cpu_std_req_n;
  logic [7:0] fast_cnt, std_cnt;
  int fail_count = 0;
  int n_tests = 0;
  int seed = 32'hF8824058;
  int pri[11];
  int a, b, w, l, t;
  int exp_q[$];

  always #2.5 clk_sys = ~clk_sys;

  vpic_ctrl u_vpic_ctrl (.clk_sys(clk_sys), .arst_n(arst_n), .periph_irq(src_v[7:0]),
    .ext_fast_req_pin(ext_fast_req_pin), .ext_std_req_pin_0(src_v[8]),
    .ext_std_req_pin_1(src_v[9]), .ext_std_req_pin_2(src_v[10]), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .cpu_fast_req_n(cpu_fast_req_n), .cpu_std_req_n(cpu_std_req_n));
  vpic_cpu_model u_vpic_cpu_model (.clk_sys(clk_sys), .arst_n(arst_n),
    .cpu_fast_req_n(cpu_fast_req_n), .cpu_std_req_n(cpu_std_req_n),
    .fast_cnt(fast_cnt), .std_cnt(std_cnt));

  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      $display("mismatch %s expected %0h seen %0h", nm, exp, seen);
      fail_count++;
    end
  endtask

  task automatic close_out;
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= ad;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] ad, output logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= ad;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    // data stand in the cycle after the strobe; taken at the edge ending it
    @(posedge clk_sys);
    d = reg_rdata;
  endtask

  // bounded wait for a request level; gives up after 10 cycles
  task automatic wait_req(input logic fast, input logic e);
    logic s;
    s = fast ? cpu_fast_req_n : cpu_std_req_n;
    for (int k = 0; k < 10 && s !== e; k++)
    begin
      @(posedge clk_sys);
      s = fast ? cpu_fast_req_n : cpu_std_req_n;
    end
    chk(fast ? "fast_req_n" : "std_req_n", {31'h0, s}, {31'h0, e});
    if (s !== e)
      close_out();
  endtask

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial
  begin
    repeat (2) @(posedge clk_sys);
    arst_n <= 1'b1;
    @(posedge clk_sys);
    chk("std_req_n", {31'h0, cpu_std_req_n}, 32'h1);
    rd(vpic_pkg::OFS_SMR_BASE, rv);
    chk("mode0", rv, {26'h0, vpic_pkg::SMR_RESET});
    rd(vpic_pkg::OFS_MASK, rv);
    chk("mask", rv, 32'h0);
    rd(vpic_pkg::OFS_VECTOR, rv);
    chk("vector", rv, {28'h0, vpic_pkg::VEC_NONE});
    rd(8'hFC, rv);
    chk("unmapped", rv, 32'h0);
    ext_fast_req_pin <= 1'b0;
    wait_req(1'b1, 1'b0);
    chk("std_req_n", {31'h0, cpu_std_req_n}, 32'h1);
    ext_fast_req_pin <= 1'b1;
    wait_req(1'b1, 1'b1);
    // fast pin on falling edge: flag holds until cleared
    wr(vpic_pkg::OFS_FAST_MODE, {30'h0, vpic_pkg::TYPE_EDGE_FALL});
    ext_fast_req_pin <= 1'b0;
    wait_req(1'b1, 1'b0);
    ext_fast_req_pin <= 1'b1;
    rd(vpic_pkg::OFS_PENDING, rv);
    chk("pending_fast", rv, 32'h0000_0800);
    chk("fast_held", {31'h0, cpu_fast_req_n}, 32'h0);
    wr(vpic_pkg::OFS_CLEAR, 32'h0000_0800);
    wait_req(1'b1, 1'b1);
    rd(vpic_pkg::OFS_FAST_MODE, rv);
    chk("fast_mode", rv, {30'h0, vpic_pkg::TYPE_EDGE_FALL});
    // every source once, sensitivity type cycling through all four
    for (int i = 0; i < 11; i++)
    begin
      t = i % 4;
      src_v[i] <= (t < 2);
      wr(8'(4 * i), 32'(t << 4));
      wr(vpic_pkg::OFS_CLEAR, 32'h1 << i);
      wr(vpic_pkg::OFS_ENABLE, 32'h1 << i);
      src_v[i] <= (t >= 2);
      wait_req(1'b0, 1'b0);
      chk("fast_req_n", {31'h0, cpu_fast_req_n}, 32'h1);
      rd(vpic_pkg::OFS_VECTOR, rv);
      chk("vector", rv, i);
      src_v[i] <= (t < 2);
      wr(vpic_pkg::OFS_EOI, 32'h0);
      wait_req(1'b0, 1'b1);
      wr(vpic_pkg::OFS_DISABLE, 32'h1 << i);
    end
    // disabled source active: no request
    wr(vpic_pkg::OFS_SMR_BASE, 32'h20);
    src_v <= 11'h001;
    repeat (4) @(posedge clk_sys);
    chk("std_req_n", {31'h0, cpu_std_req_n}, 32'h1);
    src_v <= 11'h000;
    // random priorities, rising edges, two sources at once
    for (int i = 0; i < 11; i++)
    begin
      pri[i] = $random(seed) & 7;
      wr(8'(4 * i), 32'h30 | pri[i]);
    end
    wr(vpic_pkg::OFS_CLEAR, 32'h7FF);
    wr(vpic_pkg::OFS_ENABLE, 32'h7FF);
    for (int n = 0; n < 6; n++)
    begin
      a = ($random(seed) & 255) % 11;
      b = (a + 1 + (($random(seed) & 255) % 10)) % 11;
      w = (pri[b] > pri[a] || (pri[b] == pri[a] && b < a)) ? b : a;
      l = (w == a) ? b : a;
      exp_q.push_back(w);
      exp_q.push_back(l);
      src_v <= (11'h1 << a) | (11'h1 << b);
      @(posedge clk_sys);
      src_v <= 11'h000;
      wait_req(1'b0, 1'b0);
      rd(vpic_pkg::OFS_PENDING, rv);
      chk("pending", rv, (32'h1 << a) | (32'h1 << b));
      rd(vpic_pkg::OFS_VECTOR, rv);
      chk("winner", rv, exp_q.pop_front());
      rd(vpic_pkg::OFS_STATUS, rv);
      chk("status", rv, {26'h0, vpic_pkg::VPIC_SERV, 4'(w)});
      wr(vpic_pkg::OFS_EOI, 32'h0);
      wait_req(1'b0, 1'b0);
      rd(vpic_pkg::OFS_VECTOR, rv);
      chk("second", rv, exp_q.pop_front());
      wr(vpic_pkg::OFS_EOI, 32'h0);
      wait_req(1'b0, 1'b1);
    end
    chk("fast_cnt", {24'h0, fast_cnt}, 32'h2);
    chk("std_cnt", {24'h0, std_cnt}, 32'd23);
    close_out();
  end
endmodule // tb
